// ### design/asp_pager.sv
`timescale 1ns/100ps

module asp_pager (
    input  wire logic                   sys_clk,
    input  wire logic                   arst_n,
    input  wire asp_pkg::asp_host_req_t host_req,
    output asp_pkg::asp_host_rsp_t      host_rsp,
    output asp_pkg::asp_host_req_t      ctrl_req,
    input  wire logic [7:0]             ctrl_rdata,
    input  wire asp_pkg::asp_rx_wr_t    rx_wr,
    input  wire asp_pkg::asp_tx_rd_t    tx_rd,
    output logic [7:0]                  tx_rd_data,
    output logic [1:0]                  tx_pro_mode,
    output logic [1:0]                  page_sel
);

    // ----------------------------------------------------------------
    // state and helpers
    // ----------------------------------------------------------------
    asp_pkg::asp_state_t st_reg;
    asp_pkg::asp_state_t st_next;
    logic [1:0][7:0]     crc_val;
    logic [7:0]          local_rd;
    logic [5:0]          entry;
    logic                in_range;
    logic                hit_sel;

    // serial crc, stream bit 0 (byte msb) first, reflected polynomial
    function automatic logic [7:0] asp_crc(input asp_pkg::asp_buf_t cs, input logic ch);
        logic [7:0] c;
        logic       fb;
        c  = asp_pkg::CRC_INIT;
        fb = 1'b0;
        for (int i = 0; i < asp_pkg::CRC_DATA_BYTES; i++) begin
            for (int b = 7; b >= 0; b--) begin
                fb = c[0] ^ cs[2*i + int'(ch)][b];
                c  = c >> 1;
                if (fb) begin
                    c = c ^ asp_pkg::CRC_POLY_REFL;
                end
            end
        end
        return c;
    endfunction : asp_crc

    // one crc engine per transmitted channel
    for (genvar ch = 0; ch < 2; ch++) begin : g_crc
        assign crc_val[ch] = asp_crc(st_reg.tx_cs, 1'(ch));
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // entries 0x30-0x3f and 0x70-0x7e are holes in both buffers
    assign entry    = host_req.addr[5:0];
    assign in_range = (entry[5:4] != asp_pkg::ENTRY_HOLE_HI);
    assign hit_sel  = (host_req.addr == asp_pkg::ADDR_PAGE_SEL);

    // buffer read value for the current page; reserved page reads zero
    always_comb begin
        local_rd = 8'h00;
        if (in_range) begin
            case (st_reg.page)
                asp_pkg::PAGE_RX: begin
                    local_rd = host_req.addr[asp_pkg::UD_SEL_BIT] ? st_reg.rx_ud[entry]
                                                                  : st_reg.rx_cs[entry];
                end
                asp_pkg::PAGE_TX: begin
                    local_rd = host_req.addr[asp_pkg::UD_SEL_BIT] ? st_reg.tx_ud[entry]
                                                                  : st_reg.tx_cs[entry];
                end
                default: begin
                    local_rd = 8'h00;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // reads answer two edges after the request so control-page reads,
    // which go out and come back, share the same latency as buffers
    always_comb begin
        st_next             = st_reg;
        st_next.s1_valid    = 1'b0;
        st_next.s1_ctrl     = 1'b0;
        st_next.ctrl.valid  = 1'b0;
        st_next.rsp.valid   = 1'b0;
        if (host_req.valid) begin
            if (hit_sel) begin
                if (host_req.write) begin
                    st_next.page = host_req.wdata[asp_pkg::PAGE_LSB +: 2];
                end
            end else if (st_reg.page == asp_pkg::PAGE_CTRL) begin
                st_next.ctrl = host_req;
            end else if (st_reg.page == asp_pkg::PAGE_TX && host_req.write && in_range) begin
                if (host_req.addr[asp_pkg::UD_SEL_BIT]) begin
                    st_next.tx_ud[entry] = host_req.wdata;
                end else begin
                    st_next.tx_cs[entry] = host_req.wdata;
                end
            end
            if (!host_req.write) begin
                st_next.s1_valid = 1'b1;
                st_next.s1_ctrl  = !hit_sel && (st_reg.page == asp_pkg::PAGE_CTRL);
                st_next.s1_data  = hit_sel ? {asp_pkg::PAGE_PAD_ZERO, st_reg.page}
                                           : local_rd;
            end
        end
        // second stage: pick the outside answer for control-page reads
        st_next.rsp.valid = st_reg.s1_valid;
        if (st_reg.s1_valid) begin
            st_next.rsp.rdata = st_reg.s1_ctrl ? ctrl_rdata : st_reg.s1_data;
        end
        // receiver fills its buffers; host side is read-only there
        if (rx_wr.valid) begin
            if (rx_wr.is_ud) begin
                st_next.rx_ud[{rx_wr.byte_idx, rx_wr.chan}] = rx_wr.data;
            end else begin
                st_next.rx_cs[{rx_wr.byte_idx, rx_wr.chan}] = rx_wr.data;
            end
        end
        // transmitter fetch; crc replaces stored byte 23 in professional mode
        if (tx_rd.valid) begin
            if (tx_rd.is_ud) begin
                st_next.tx_rd_data = st_reg.tx_ud[{tx_rd.byte_idx, tx_rd.chan}];
            end else if (tx_rd.byte_idx == asp_pkg::CRC_BYTE_IDX && st_reg.tx_pro[tx_rd.chan]) begin
                st_next.tx_rd_data = crc_val[tx_rd.chan];
            end else begin
                st_next.tx_rd_data = st_reg.tx_cs[{tx_rd.byte_idx, tx_rd.chan}];
            end
        end
        // mode bit is buffer bit 0, which sits in the byte msb
        st_next.tx_pro[0] = st_reg.tx_cs[0][asp_pkg::PRO_BIT_POS];
        st_next.tx_pro[1] = st_reg.tx_cs[1][asp_pkg::PRO_BIT_POS];
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg      <= '0;
            st_reg.page <= asp_pkg::PAGE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign host_rsp    = st_reg.rsp;
    assign ctrl_req    = st_reg.ctrl;
    assign tx_rd_data  = st_reg.tx_rd_data;
    assign tx_pro_mode = st_reg.tx_pro;
    assign page_sel    = st_reg.page;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_rd_req;
        host_req.valid && !host_req.write;
    endsequence

    sequence s_sel_rd;
        host_req.valid && !host_req.write && hit_sel;
    endsequence

    property p_page_wr;
        host_req.valid && host_req.write && hit_sel |=> page_sel == $past(host_req.wdata[1:0]);
    endproperty
    a_page_wr: assert property (p_page_wr) else $error("page write not taken");

    property p_rd_latency;
        s_rd_req |-> ##1 (host_rsp.valid == $past(host_req.valid && !host_req.write, 2))
            ##1 host_rsp.valid;
    endproperty
    a_rd_latency: assert property (p_rd_latency) else $error("read answer late");

    property p_sel_rd;
        s_sel_rd |-> ##2 host_rsp.rdata == {6'h00, $past(page_sel, 2)};
    endproperty
    a_sel_rd: assert property (p_sel_rd) else $error("page readback wrong");

    property p_reset_page;
        @(posedge sys_clk) disable iff (1'b0) !arst_n |-> page_sel == 2'h0;
    endproperty
    a_reset_page: assert property (p_reset_page) else $error("page not zero in reset");

    property p_ctrl_fwd;
        host_req.valid && !hit_sel && page_sel == 2'h0 |=> ctrl_req.valid
            && ctrl_req.addr == $past(host_req.addr)
            && ctrl_req.write == $past(host_req.write)
            && ctrl_req.wdata == $past(host_req.wdata);
    endproperty
    a_ctrl_fwd: assert property (p_ctrl_fwd) else $error("control access lost");

    property p_rx_rd;
        s_rd_req ##0 (page_sel == 2'h1 && !hit_sel) |-> ##2 host_rsp.rdata ==
            $past(entry > 6'h2f ? 8'h00
                : host_req.addr[6] ? st_reg.rx_ud[entry] : st_reg.rx_cs[entry], 2);
    endproperty
    a_rx_rd: assert property (p_rx_rd) else $error("receiver buffer read wrong");

    property p_tx_wr;
        host_req.valid && host_req.write && page_sel == 2'h2 && !hit_sel && in_range
            && !host_req.addr[6] |=> st_reg.tx_cs[$past(entry)] == $past(host_req.wdata);
    endproperty
    a_tx_wr: assert property (p_tx_wr) else $error("transmit buffer write lost");

    property p_rx_cs;
        rx_wr.valid && !rx_wr.is_ud |=>
            st_reg.rx_cs[{$past(rx_wr.byte_idx), $past(rx_wr.chan)}] == $past(rx_wr.data);
    endproperty
    a_rx_cs: assert property (p_rx_cs) else $error("status byte misplaced");

    property p_pro;
        ##1 tx_pro_mode == {$past(st_reg.tx_cs[1][7]), $past(st_reg.tx_cs[0][7])};
    endproperty
    a_pro: assert property (p_pro) else $error("mode flag wrong");

    property p_crc;
        tx_rd.valid && !tx_rd.is_ud && tx_rd.byte_idx == 5'h17 && tx_pro_mode[tx_rd.chan]
            |=> tx_rd_data == $past(crc_val[tx_rd.chan]);
    endproperty
    a_crc: assert property (p_crc) else $error("crc not inserted");

    property p_rx_ud;
        rx_wr.valid && rx_wr.is_ud |=>
            st_reg.rx_ud[{$past(rx_wr.byte_idx), $past(rx_wr.chan)}] == $past(rx_wr.data);
    endproperty
    a_rx_ud: assert property (p_rx_ud) else $error("user byte misplaced");

    property p_rsvd;
        host_req.valid && page_sel == 2'h3 && !hit_sel
            |=> $stable(st_reg.tx_cs) && $stable(st_reg.tx_ud) && !ctrl_req.valid;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved page took write");

    property p_rsvd_rd;
        s_rd_req ##0 (page_sel == 2'h3 && !hit_sel) |-> ##2 host_rsp.rdata == 8'h00;
    endproperty
    a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved page read nonzero");

endmodule : asp_pager

// ### design/asp_pkg.sv
package asp_pkg;

    // ----------------------------------------------------------------
    // address map and page codes
    // ----------------------------------------------------------------
    localparam logic [6:0] ADDR_PAGE_SEL  = 7'h7f;
    localparam int         PAGE_LSB       = 0;
    localparam logic [1:0] PAGE_CTRL      = 2'h0;
    localparam logic [1:0] PAGE_RX        = 2'h1;
    localparam logic [1:0] PAGE_TX        = 2'h2;
    localparam logic [1:0] PAGE_RSVD      = 2'h3;
    localparam logic [1:0] PAGE_RESET     = 2'h0;
    localparam logic [5:0] PAGE_PAD_ZERO  = 6'h00;
    localparam int         UD_SEL_BIT     = 6;
    localparam logic [1:0] ENTRY_HOLE_HI  = 2'h3;

    // ----------------------------------------------------------------
    // buffer shape and channel-status fields
    // ----------------------------------------------------------------
    localparam int         BUF_ENTRIES    = 48;
    localparam logic [4:0] CRC_BYTE_IDX   = 5'h17;
    localparam int         PRO_BIT_POS    = 7;
    localparam int         CRC_DATA_BYTES = 23;
    localparam logic [7:0] CRC_INIT       = 8'hff;
    localparam logic [7:0] CRC_POLY_REFL  = 8'hb8;
    localparam logic [7:0] BYTE_RESET     = 8'h00;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [6:0] addr;
        logic [7:0] wdata;
    } asp_host_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } asp_host_rsp_t;

    typedef struct packed {
        logic       valid;
        logic       is_ud;
        logic [4:0] byte_idx;
        logic       chan;
        logic [7:0] data;
    } asp_rx_wr_t;

    typedef struct packed {
        logic       valid;
        logic       is_ud;
        logic [4:0] byte_idx;
        logic       chan;
    } asp_tx_rd_t;

    typedef logic [BUF_ENTRIES-1:0][7:0] asp_buf_t;

    typedef struct packed {
        logic [1:0]    page;
        logic          s1_valid;
        logic          s1_ctrl;
        logic [7:0]    s1_data;
        asp_host_rsp_t rsp;
        asp_host_req_t ctrl;
        logic [7:0]    tx_rd_data;
        logic [1:0]    tx_pro;
        asp_buf_t      rx_cs;
        asp_buf_t      rx_ud;
        asp_buf_t      tx_cs;
        asp_buf_t      tx_ud;
    } asp_state_t;

endpackage : asp_pkg

// ### bench/asp_ctrl_bank_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// control and status bank stand-in
// ----------------------------------------------------------------
module asp_ctrl_bank_model (
    input  wire logic                   sys_clk,
    input  wire logic                   arst_n,
    input  wire asp_pkg::asp_host_req_t ctrl_req,
    output logic [7:0]                  ctrl_rdata
);
    logic [7:0] noise_reg;

    // free counter so an unselected bank never shows a stale byte
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) noise_reg <= 8'h00;
        else noise_reg <= noise_reg + 8'h01;
    end

    // answer is a fixed function of the address while selected
    assign ctrl_rdata = ctrl_req.valid ? {1'b1, ctrl_req.addr} : noise_reg;
endmodule : asp_ctrl_bank_model

// ### bench/asp_pager_bench.sv
`timescale 1ns/100ps

module asp_pager_bench;
    logic                   sys_clk;
    logic                   arst_n;
    asp_pkg::asp_host_req_t host_req;
    asp_pkg::asp_host_rsp_t host_rsp;
    asp_pkg::asp_host_req_t ctrl_req;
    logic [7:0]             ctrl_rdata;
    asp_pkg::asp_rx_wr_t    rx_wr;
    asp_pkg::asp_tx_rd_t    tx_rd;
    logic [7:0]             tx_rd_data;
    logic [1:0]             tx_pro_mode;
    logic [1:0]             page_sel;
    logic [7:0]             mem [4][128];
    int                     fail_count;
    int                     samples_checked;

    asp_pager uut (.sys_clk(sys_clk), .arst_n(arst_n), .host_req(host_req),
        .host_rsp(host_rsp), .ctrl_req(ctrl_req), .ctrl_rdata(ctrl_rdata), .rx_wr(rx_wr),
        .tx_rd(tx_rd), .tx_rd_data(tx_rd_data), .tx_pro_mode(tx_pro_mode), .page_sel(page_sel));
    asp_ctrl_bank_model bank (.sys_clk(sys_clk), .arst_n(arst_n), .ctrl_req(ctrl_req),
        .ctrl_rdata(ctrl_rdata));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // answer lands in the cycle after the one holding ctrl_req
    task automatic host(input logic w, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] rd);
        @(posedge sys_clk);
        #1 host_req = '{1'b1, w, a, d};
        @(posedge sys_clk);
        #1 host_req.valid = 1'b0;
        rd = 8'h00;
        if (!w) begin
            @(posedge sys_clk);
            #1 chk({7'h0, host_rsp.valid}, 8'h01, "answer strobe");
            rd = host_rsp.rdata;
        end
    endtask : host

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string what);
        logic [7:0] r;
        host(1'b0, a, 8'h00, r);
        chk(r, exp, what);
    endtask : rd_chk

    task automatic rxw(input logic ud, input logic [4:0] i, input logic ch, input logic [7:0] d);
        @(posedge sys_clk);
        #1 rx_wr = '{1'b1, ud, i, ch, d};
        @(posedge sys_clk);
        #1 rx_wr.valid = 1'b0;
    endtask : rxw

    task automatic txf(input logic ud, input logic [4:0] i, input logic ch);
        @(posedge sys_clk);
        #1 tx_rd = '{1'b1, ud, i, ch};
        @(posedge sys_clk);
        #1 tx_rd.valid = 1'b0;
    endtask : txf

    // byte 23 of a professional channel is replaced by its crc on fetch
    function automatic logic [7:0] exp_tx(input logic ud, input logic [4:0] i, input logic ch);
        logic [7:0] c;
        logic       fb;
        c = mem[2][{ud, i, ch}];
        if (!ud && i == asp_pkg::CRC_BYTE_IDX && mem[2][{6'h0, ch}][7]) begin
            c = asp_pkg::CRC_INIT;
            for (int k = 0; k < 23; k++) begin
                for (int b = 7; b >= 0; b--) begin
                    fb = c[0] ^ mem[2][2 * k + ch][b];
                    c = {1'b0, c[7:1]} ^ (fb ? asp_pkg::CRC_POLY_REFL : 8'h00);
                end
            end
        end
        return c;
    endfunction : exp_tx

    task automatic complete_run();
        $display("checked %0d, failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------
    // clock, watchdog and tests
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // tests need about 1k cycles; 10k means a hang
    initial begin
        #100us;
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        logic [7:0] r;
        logic [7:0] d;
        logic [6:0] a;
        logic [4:0] i;
        logic       ud;
        logic       ch;
        fail_count = 0;
        samples_checked = 0;
        host_req = '0;
        rx_wr = '0;
        tx_rd = '0;
        arst_n = 1'b0;
        foreach (mem[p, q]) mem[p][q] = 8'h00;
        void'($urandom(89));
        repeat (10) @(posedge sys_clk);
        #1 arst_n = 1'b1;
        rd_chk(7'h7f, 8'h00, "reset page");
        rd_chk(7'h05, 8'h85, "control read");
        $display("test reset done");
        for (int pg = 1; pg < 4; pg++) begin
            host(1'b1, 7'h7f, {6'($urandom), 2'(pg)}, r);
            chk({6'h0, page_sel}, 8'(pg), "page output");
            rd_chk(7'h7f, 8'(pg), "page readback");
            repeat (150) begin
                a = 7'($urandom % 127);
                d = 8'($urandom);
                i = 5'($urandom % 24);
                ud = 1'($urandom);
                ch = 1'($urandom);
                case ($urandom % 4)
                    0: begin
                        rxw(ud, i, ch, d);
                        mem[1][{ud, i, ch}] = d;
                    end
                    1: begin
                        host(1'b1, a, d, r);
                        if (pg == 2 && a[5:0] < 6'd48) mem[2][a] = d;
                    end
                    2: rd_chk(a, mem[pg][a], "buffer read");
                    default: begin
                        txf(ud, i, ch);
                        chk(tx_rd_data, exp_tx(ud, i, ch), "fetch");
                    end
                endcase
            end
            $display("test page %0d done", pg);
        end
        host(1'b1, 7'h7f, 8'h02, r);
        host(1'b1, 7'h00, 8'h80, r);
        host(1'b1, 7'h01, 8'h7f, r);
        mem[2][0] = 8'h80;
        mem[2][1] = 8'h7f;
        @(posedge sys_clk);
        #1 chk({6'h0, tx_pro_mode}, 8'h01, "mode bits");
        for (int c = 0; c < 2; c++) begin
            txf(1'b0, 5'h17, 1'(c));
            chk(tx_rd_data, exp_tx(1'b0, 5'h17, 1'(c)), "byte 23 fetch");
            rd_chk(7'(46 + c), mem[2][46 + c], "byte 23 stored");
        end
        $display("test professional done");
        host(1'b1, 7'h7f, 8'h00, r);
        rd_chk(7'h12, 8'h92, "control again");
        // forwarded write stands one cycle, seen just after its launch edge
        host(1'b1, 7'h12, 8'h5a, r);
        chk({ctrl_req.valid, ctrl_req.write, 6'h0}, 8'hc0, "control write strobe");
        chk({1'b0, ctrl_req.addr}, 8'h12, "control write address");
        chk(ctrl_req.wdata, 8'h5a, "control write data");
        $display("test return done");
        complete_run();
    end
endmodule : asp_pager_bench
